// ===== rtl/cfpm_pkg.sv
// Package with constants and types for the frequency pulse mapper.
package cfpm_pkg;

    // Width of the signed impulse area.
    localparam int AREA_W = 3;
    // Impulse areas for each bit pair.
    localparam logic signed [2:0] AREA_P3 = 3'sd3;
    localparam logic signed [2:0] AREA_P1 = 3'sd1;
    localparam logic signed [2:0] AREA_M1 = -3'sd1;
    localparam logic signed [2:0] AREA_M3 = -3'sd3;
    // Modulation index numerators over a denominator of sixteen.
    localparam logic [3:0] MOD_INDEX_LOW  = 4'h4;
    localparam logic [3:0] MOD_INDEX_HIGH = 4'h5;
    // Bits per symbol and pulse length in symbols.
    localparam int BITS_PER_SYM  = 2;
    localparam int PULSE_SYMBOLS = 3;
    // Default samples per symbol and table resolution.
    localparam int SPS_DEF    = 8;
    localparam int TAB_W_DEF  = 12;
    // Supported source bit rates in bits per second.
    localparam longint BIT_RATE_MIN = 64'd5000000;
    localparam longint BIT_RATE_MAX = 64'd20000000;
    // Reset values.
    localparam logic RST_PHASE = 1'b0;

    // Phase of the bit pairing.
    typedef enum logic [0:0]
    {
        PAIR_FIRST  = 1'b0,
        PAIR_SECOND = 1'b1
    } cfpm_pair_e;

    // One symbol's weighted impulse as it enters the shaping history.
    typedef struct packed
    {
        logic signed [2:0] area;
        logic              high_index;
    } cfpm_imp_s;

endpackage

// ===== rtl/cfpm_pulse_rom.sv
// Pulse shape table with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module cfpm_pulse_rom
    import cfpm_pkg::*;
#(
    parameter int DEPTH = PULSE_SYMBOLS * SPS_DEF,
    parameter int DW    = TAB_W_DEF,
    parameter int AW    = $clog2(DEPTH)
)
(
    input  wire logic          clk_i,
    input  wire logic [AW-1:0] addr_i,
    output var  logic [DW-1:0] data_o
);

    // Table of 1 - cos(2 pi t / 3T), scaled so its peak is 2**DW - 1.
    logic [DW-1:0] table_mem [DEPTH];

    // Fill the table at elaboration from the raised-cosine formula.
    initial
    begin
        for (int k = 0; k < DEPTH; k++)
        begin
            table_mem[k] = DW'($rtoi(((2.0 ** DW) - 1.0) * 0.5 *
                (1.0 - $cos(2.0 * 3.14159265358979 * (k + 0.5) / DEPTH))));
        end
    end

    // Read data leaves through a register.
    always_ff @(posedge clk_i)
    begin
        data_o <= table_mem[addr_i];
    end

endmodule
`default_nettype wire

// ===== rtl/cfpm_mapper.sv
// Bit pair to shaped instantaneous frequency mapper.
`timescale 1ns/1ps
`default_nettype none
module cfpm_mapper
    import cfpm_pkg::*;
#(
    parameter int     SPS      = SPS_DEF,
    parameter int     TAB_W    = TAB_W_DEF,
    parameter longint BIT_RATE = BIT_RATE_MIN,
    parameter int     OUT_W    = TAB_W + 8
)
(
    input  wire logic             CORE_CLK_I,
    input  wire logic             RST_N_I,
    input  wire logic             BIT_VALID_I,
    input  wire logic             SOURCE_BIT_I,
    input  wire logic             SAMPLE_TICK_I,
    output var  logic             SYMBOL_STROBE_O,
    output var  logic signed [2:0] IMPULSE_AREA_O,
    output var  logic             HIGH_INDEX_O,
    output var  logic signed [OUT_W-1:0] FREQ_O,
    output var  logic             FREQ_VALID_O
);

    localparam int DEPTH = PULSE_SYMBOLS * SPS;
    localparam int AW    = $clog2(DEPTH);
    localparam int PW    = $clog2(SPS);

    // Refuse settings the logic cannot serve.
    initial
    begin
        if (SPS < 2 || (SPS & (SPS - 1)) != 0)
            $error("SPS must be a power of two of at least two.");
        if (BIT_RATE < BIT_RATE_MIN || BIT_RATE > BIT_RATE_MAX)
            $error("Bit rate outside the supported range.");
        if (OUT_W < TAB_W + 6)
            $error("Output too narrow for summed pulses.");
    end

    // Map a bit pair, earlier bit first, to its signed impulse area.
    function automatic logic signed [2:0] pair_area(input logic first_b, input logic second_b);
        logic signed [2:0] a;
        a = AREA_M3;
        unique case ({first_b, second_b})
            2'b11: a = AREA_P3;
            2'b10: a = AREA_P1;
            2'b01: a = AREA_M1;
            2'b00: a = AREA_M3;
        endcase
        return a;
    endfunction

    // Pairing phase and the held earlier bit.
    cfpm_pair_e pair_reg;
    logic       first_bit_reg;
    // History of the three most recent impulses, newest first.
    cfpm_imp_s  hist_reg [PULSE_SYMBOLS];
    // Index parity of the next symbol.
    logic       next_high_reg;
    // Sample position inside the current symbol.
    logic [PW-1:0] pos_reg;
    // Sequencer across the three overlapping pulses.
    logic [1:0] tap_reg;
    logic       busy_reg;
    // Accumulator of the running sum.
    logic signed [OUT_W-1:0] acc_reg;
    logic       tap_d_reg;
    logic [1:0] tap_idx_d_reg;
    logic       last_d_reg;

    // Bits are 0 or 1, taken one per half symbol; pairs complete on the second.
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            pair_reg      <= PAIR_FIRST;
            first_bit_reg <= RST_PHASE;
        end
        else if (BIT_VALID_I)
        begin
            if (pair_reg == PAIR_FIRST)
            begin
                first_bit_reg <= SOURCE_BIT_I;
                pair_reg      <= PAIR_SECOND;
            end
            else
            begin
                pair_reg <= PAIR_FIRST;
            end
        end
    end

    // A symbol completes on the second bit of a pair.
    logic sym_done;
    assign sym_done = BIT_VALID_I && (pair_reg == PAIR_SECOND);

    // Shift a new impulse into history once per symbol, alternating index.
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            for (int k = 0; k < PULSE_SYMBOLS; k++)
                hist_reg[k] <= '0;
            next_high_reg   <= RST_PHASE;
            SYMBOL_STROBE_O <= 1'b0;
            IMPULSE_AREA_O  <= '0;
            HIGH_INDEX_O    <= 1'b0;
        end
        else
        begin
            SYMBOL_STROBE_O <= sym_done;
            if (sym_done)
            begin
                hist_reg[0].area       <= pair_area(first_bit_reg, SOURCE_BIT_I);
                hist_reg[0].high_index <= next_high_reg;
                for (int k = 1; k < PULSE_SYMBOLS; k++)
                    hist_reg[k] <= hist_reg[k-1];
                next_high_reg  <= ~next_high_reg;
                IMPULSE_AREA_O <= pair_area(first_bit_reg, SOURCE_BIT_I);
                HIGH_INDEX_O   <= next_high_reg;
            end
        end
    end

    // Sample position restarts at each symbol and advances on ticks taken while idle, holding at SPS-1.
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            pos_reg <= '0;
        else if (sym_done)
            pos_reg <= '0;
        else if (SAMPLE_TICK_I && busy_reg == 1'b0 && pos_reg != PW'(SPS - 1))
            pos_reg <= pos_reg + PW'(1);
    end

    // Each sample walks the three taps; tap k reads pulse offset k*SPS+pos.
    logic start;
    assign start = SAMPLE_TICK_I && !busy_reg;
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            busy_reg <= 1'b0;
            tap_reg  <= '0;
        end
        else if (start)
        begin
            busy_reg <= 1'b1;
            tap_reg  <= '0;
        end
        else if (busy_reg)
        begin
            if (tap_reg == 2'(PULSE_SYMBOLS - 1))
                busy_reg <= 1'b0;
            else
                tap_reg <= tap_reg + 2'd1;
        end
    end

    // Pulse table address for the current tap.
    logic [AW-1:0] rom_addr;
    logic [TAB_W-1:0] rom_data;
    assign rom_addr = AW'(tap_reg) * AW'(SPS) + AW'(pos_reg);

    cfpm_pulse_rom #(
        .DEPTH (DEPTH),
        .DW    (TAB_W),
        .AW    (AW)
    ) u_rom (
        .clk_i  (CORE_CLK_I),
        .addr_i (rom_addr),
        .data_o (rom_data)
    );

    // Align tap bookkeeping with the registered table output.
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            tap_d_reg     <= 1'b0;
            tap_idx_d_reg <= '0;
            last_d_reg    <= 1'b0;
        end
        else
        begin
            tap_d_reg     <= busy_reg;
            tap_idx_d_reg <= tap_reg;
            last_d_reg    <= busy_reg && tap_reg == 2'(PULSE_SYMBOLS - 1);
        end
    end

    // Weight: area times index numerator; pi/(16*6T) is a fixed output scale.
    logic signed [7:0] weight;
    logic signed [OUT_W-1:0] term;
    cfpm_imp_s cur;
    always_comb
    begin
        cur    = hist_reg[tap_idx_d_reg];
        weight = 8'(cur.area) * 8'(signed'({1'b0, cur.high_index ? MOD_INDEX_HIGH
                                                                 : MOD_INDEX_LOW}));
        term   = OUT_W'(weight) * signed'(OUT_W'({1'b0, rom_data}));
    end

    // Sum the taps; positive areas give positive words, i.e. higher frequency.
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            acc_reg      <= '0;
            FREQ_O       <= '0;
            FREQ_VALID_O <= 1'b0;
        end
        else
        begin
            FREQ_VALID_O <= last_d_reg;
            if (tap_d_reg)
            begin
                if (tap_idx_d_reg == 2'd0)
                    acc_reg <= term;
                else
                    acc_reg <= acc_reg + term;
            end
            if (last_d_reg)
                FREQ_O <= acc_reg + term;
        end
    end

endmodule
`default_nettype wire

// ===== verification/cfpm_checker.sv
// Port checker for the frequency pulse mapper.
`timescale 1ns/1ps
`default_nettype none
module cfpm_checker
    import cfpm_pkg::*;
#(
    parameter int OUT_W = 20
)
(
    input  wire logic                    CORE_CLK_I,
    input  wire logic                    RST_N_I,
    input  wire logic                    BIT_VALID_I,
    input  wire logic                    SOURCE_BIT_I,
    input  wire logic                    SAMPLE_TICK_I,
    input  wire logic                    SYMBOL_STROBE_O,
    input  wire logic signed [2:0]       IMPULSE_AREA_O,
    input  wire logic                    HIGH_INDEX_O,
    input  wire logic signed [OUT_W-1:0] FREQ_O,
    input  wire logic                    FREQ_VALID_O
);
    logic       ph_reg;  // Set while waiting for the second bit.
    logic       fb_reg;  // Earlier bit of the pair.
    logic       hx_reg;  // Index expected for the next symbol.
    logic [1:0] bz_reg;  // Busy cycles left after a taken tick.
    logic [2:0] ar_reg;  // Expected area of the last pair.
    wire  logic acc = RST_N_I && SAMPLE_TICK_I && bz_reg == 2'h0;
    // Shadow of pairing, index alternation and the sample busy window.
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            ph_reg <= 1'b0;
            hx_reg <= 1'b0;
            bz_reg <= 2'h0;
        end
        else
        begin
            if (BIT_VALID_I)
                ph_reg <= !ph_reg;
            if (BIT_VALID_I && !ph_reg)
                fb_reg <= SOURCE_BIT_I;
            if (BIT_VALID_I && ph_reg)
            begin
                ar_reg <= {!fb_reg, SOURCE_BIT_I, 1'b1};
                hx_reg <= !hx_reg;
            end
            bz_reg <= acc ? 2'h3 : bz_reg - {1'b0, bz_reg != 2'h0};
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence pair_s;
        BIT_VALID_I && ph_reg;
    endsequence
    a_pair_strobe: assert property (pair_s |=> SYMBOL_STROBE_O)
        else $error("strobe missing after a pair");
    a_strobe_cause: assert property (SYMBOL_STROBE_O |-> $past(BIT_VALID_I && ph_reg))
        else $error("strobe without a pair");
    a_area_map: assert property (pair_s |=> IMPULSE_AREA_O == ar_reg)
        else $error("wrong impulse area");
    a_index_alt: assert property (pair_s |=> HIGH_INDEX_O == !hx_reg)
        else $error("index not alternating");
    a_area_hold: assert property (!SYMBOL_STROBE_O |-> $stable(IMPULSE_AREA_O))
        else $error("area changed without strobe");
    a_freq_latency: assert property (acc |-> ##5 FREQ_VALID_O)
        else $error("sample answer late");
    a_freq_cause: assert property (FREQ_VALID_O |-> $past(acc, 5))
        else $error("sample answer without tick");
    a_freq_hold: assert property (!FREQ_VALID_O |-> $stable(FREQ_O))
        else $error("frequency word changed");
    a_reset_clear: assert property ($rose(RST_N_I) |-> FREQ_O == 0 && !HIGH_INDEX_O)
        else $error("outputs not cleared by reset");
endmodule
bind cfpm_mapper cfpm_checker #(.OUT_W(OUT_W)) i_cfpm_checker (.CORE_CLK_I, .RST_N_I,
    .BIT_VALID_I, .SOURCE_BIT_I, .SAMPLE_TICK_I, .SYMBOL_STROBE_O, .IMPULSE_AREA_O,
    .HIGH_INDEX_O, .FREQ_O, .FREQ_VALID_O);
`default_nettype wire

// ===== verification/cfpm_source.sv
// Serial source model that feeds the mapper one bit per request.
`timescale 1ns/1ps
`default_nettype none
module cfpm_source
(
    input  wire logic clk_i,
    input  wire logic send_i,
    input  wire logic bit_i,
    input  wire logic scr_i,
    output var  logic valid_o = 1'b0,
    output var  logic bit_o = 1'b0
);
    logic [14:0] lfsr_reg = 15'h7fff;  // Fifteen-bit randomizer state.
    // Drives a bit at the falling edge; a released line inverts at every falling edge.
    always @(negedge clk_i)
    begin
        valid_o <= send_i;
        if (send_i)
        begin
            bit_o    <= scr_i ? lfsr_reg[14] : bit_i;
            lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
        end
        else
            bit_o <= !bit_o;
    end
endmodule
`default_nettype wire

// ===== verification/test_cfpm_mapper.sv
// Self-checking testbench of the frequency pulse mapper.
`timescale 1ns/1ps
`default_nettype none
module test_cfpm_mapper;
    import cfpm_pkg::*;
    localparam int OW = TAB_W_DEF + 8;
    localparam logic signed [2:0] EXP [4] = '{AREA_M3, AREA_M1, AREA_P1, AREA_P3};
    logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, send = 1'b0, sbit = 1'b0, scr = 1'b0;
    wire logic bv, sb, stb, hx, fv;
    wire logic signed [2:0] area;
    wire logic signed [OW-1:0] freq;
    int fails = 0, samples_checked = 0;
    logic signed [OW-1:0] f;
    int n;
    cfpm_mapper i_cfpm_mapper (.CORE_CLK_I(clk), .RST_N_I(rst_n), .BIT_VALID_I(bv),
        .SOURCE_BIT_I(sb), .SAMPLE_TICK_I(tick), .SYMBOL_STROBE_O(stb),
        .IMPULSE_AREA_O(area), .HIGH_INDEX_O(hx), .FREQ_O(freq), .FREQ_VALID_O(fv));
    cfpm_source i_cfpm_source (.clk_i(clk), .send_i(send), .bit_i(sbit), .scr_i(scr),
        .valid_o(bv), .bit_o(sb));
    // The clock runs at 10 MHz.
    initial forever #50 clk = !clk;
    task automatic check1(string nm, logic e, logic g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic check_area(logic signed [2:0] e, logic signed [2:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch area exp %0d got %0d", e, g);
        end
    endtask
    task automatic check_cnt(string nm, int e, int g);
        samples_checked++;
        if (g != e)
        begin
            fails++;
            $display("mismatch %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_reset;
        @(negedge clk) rst_n <= 1'b0;
        repeat (12) @(negedge clk);
        rst_n <= 1'b1;
    endtask
    // The source launches the bit one falling edge after the request; wait until it is taken.
    task automatic send_bit(logic b);
        @(negedge clk) send <= 1'b1;
        sbit <= b;
        @(negedge clk) send <= 1'b0;
        @(negedge clk);
    endtask
    // Sends one pair and judges strobe, area and index one cycle later.
    task automatic sym(logic [1:0] c, logic h);
        send_bit(c[1]);
        send_bit(c[0]);
        check1("strobe", 1'b1, stb);
        check_area(EXP[c], area);
        check1("index", h, hx);
    endtask
    // Takes one sample; a second tick two cycles later must be dropped.
    task automatic sample;
        @(negedge clk) tick <= 1'b1;
        @(negedge clk) tick <= 1'b0;
        @(negedge clk) tick <= 1'b1;
        @(negedge clk) tick <= 1'b0;
        n = 0;
        repeat (12)
        begin
            @(negedge clk);
            if (fv === 1'b1)
            begin
                n++;
                f = freq;
            end
        end
        check_cnt("samples", 1, n);
    endtask
    // Every code under both index values.
    task automatic t_map;
        do_reset();
        for (int k = 0; k < 8; k++)
            sym(2'(k >> 1), k[0]);
    endtask
    // Sign of the word follows the sign of the areas.
    task automatic t_sign;
        do_reset();
        sample();
        check1("zero", 1'b1, f == 0);
        for (int k = 0; k < 4; k++)
            sym(2'h3, k[0]);
        sample();
        check1("positive", 1'b1, f > 0);
        for (int k = 0; k < 6; k++)
            sym(2'h0, k[0]);
        sample();
        check1("negative", 1'b1, f < 0);
    endtask
    // Randomized stream, then a reset in the middle of a pair.
    task automatic t_scr;
        do_reset();
        scr <= 1'b1;
        n = 0;
        repeat (10)
        begin
            send_bit(1'b0);
            send_bit(1'b0);
            n += int'(stb === 1'b1);
        end
        check_cnt("strobes", 10, n);
        scr <= 1'b0;
        send_bit(1'b1);
        do_reset();
        sym(2'h1, 1'b0);
    endtask
    initial
    begin
        t_map();
        t_sign();
        t_scr();
        stop_test();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
